// ===== verilog/dfp_regs.sv
/*
 * Register bank of the digitally pulled compensated oscillator: the two
 * halves of the signed frequency offset word, software output enable and
 * the pull range select. Writes arrive already decoded from the serial
 * slave as one-cycle strobes with a register index and 16-bit data; reads
 * are combinational on the index. Assumes one clock and a power-up reset.
 */
// Operation
// - Power up nominal with factory pull range.
// - Range and offset writable after power-up.
// - Frequency change bounded by selected pull range.
// - Register 0x02 bits 3:0 select range.
// - Step resolution follows selected range.
// - Offset is 26-bit two's complement word.
// - Offset word resets to zero.
// - Low half 0x00, high half 0x01.
// - Low first; high write commits word; a high write during the hold window is staged only, not applied.
// - Bit 10 drives output only under software.
// - Software enable resets to zero.
// - Unused bits read zero, ignore writes.
// - Range loads factory default, host may overwrite.
`timescale 1ns/1ns
module dfp_regs (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register write port from the serial slave.
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  // Register read port to the serial slave.
  input wire logic [7:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  // Output enable configuration and pin.
  input wire logic oe_sw_mode_in,
  input wire logic oe_pin_in,
  output logic out_enable_out,
  // Oscillator control.
  output logic [dfp_pkg::DFP_WORD_WIDTH-1:0] freq_offset_word_out,
  output logic [3:0] pull_range_out,
  output logic [19:0] half_range_out,
  output logic [9:0] resolution_out,
  output logic freq_update_out,
  output logic update_too_fast_out
);
  import dfp_pkg::*;

  // Host-visible register fields.
  logic [15:0] low_offset_half_reg;
  logic [9:0] high_offset_half_reg;
  logic oe_sw_reg;
  logic [3:0] pull_range_reg;
  // Word driven to the oscillator core and its next value.
  logic [DFP_WORD_WIDTH-1:0] active_word_reg;
  logic [DFP_WORD_WIDTH-1:0] active_word_next;
  // Commit strobe, rate flag and hold window counter.
  logic freq_update_reg;
  logic too_fast_reg;
  logic [11:0] pace_cnt_reg;
  // Commit state machine.
  dfp_state_type state_reg;
  dfp_state_type state_next;
  // Decoded write strobes, one per register.
  logic wr_low;
  logic wr_high;
  logic wr_range;

  // Index match used for the write decode only; the read mux compares the index directly.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr == idx);
  endfunction

  assign wr_low = wr_en_in && hit(wr_addr_in, DFP_ADDR_OFFSET_LOW);
  assign wr_high = wr_en_in && hit(wr_addr_in, DFP_ADDR_OFFSET_HIGH);
  assign wr_range = wr_en_in && hit(wr_addr_in, DFP_ADDR_PULL_RANGE);

  // Low half only stages; it never reaches the oscillator by itself.
  // Reads of the low half show the staged value, not the applied one.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      low_offset_half_reg <= DFP_OFFSET_LOW_RST;
    end else if (wr_low) begin
      low_offset_half_reg <= wr_data_in;
    end
  end

  // High half and software enable share one register; bits 15:11 are dropped.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      high_offset_half_reg <= DFP_OFFSET_HIGH_RST;
      oe_sw_reg <= DFP_OE_RST;
    end else if (wr_high) begin
      high_offset_half_reg <= wr_data_in[DFP_HIGH_BITS-1:0];
      if (oe_sw_mode_in) begin
        oe_sw_reg <= wr_data_in[DFP_OE_BIT];
      end
    end
  end

  // Pull range select: factory code at power-up, host may overwrite.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pull_range_reg <= DFP_RANGE_FACTORY;
    end else if (wr_range) begin
      pull_range_reg <= wr_data_in[DFP_RANGE_BITS-1:0];
    end
  end

  // Commit sequencing: the high write launches an apply, then a hold window
  // that spaces commits at the documented maximum update rate.
  always_comb begin
    state_next = state_reg;
    active_word_next = active_word_reg;
    case (state_reg)
      DFP_IDLE: begin
        if (wr_high) begin
          state_next = DFP_APPLY;
        end
      end
      DFP_APPLY: begin
        // Assemble the full signed word from both halves, high half just stored.
        active_word_next = {high_offset_half_reg, low_offset_half_reg};
        state_next = DFP_HOLD;
      end
      DFP_HOLD: begin
        // A high write here is stored but not applied; the pacing flag reports it.
        if (pace_cnt_reg == 12'h000) begin
          state_next = DFP_IDLE;
        end
      end
      default: begin
        state_next = DFP_IDLE;
      end
    endcase
  end

  // State, active word and commit strobe.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= DFP_IDLE;
      active_word_reg <= '0;
      freq_update_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      active_word_reg <= active_word_next;
      freq_update_reg <= (state_reg == DFP_APPLY);
    end
  end

  // Pacing counter. A high write during the hold window is still staged but
  // not applied when the window ends; it is flagged so firmware can see it
  // broke the rate limit (the host is the one bound to respect it).
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pace_cnt_reg <= 12'h000;
      too_fast_reg <= 1'b0;
    end else begin
      // The load happens in the apply cycle and leaving the hold state costs one
      // more cycle, so the real spacing is a little longer than the load value.
      if (state_reg == DFP_APPLY) begin
        pace_cnt_reg <= DFP_UPDATE_CYCLES - 12'h002;
      end else if (pace_cnt_reg != 12'h000) begin
        pace_cnt_reg <= pace_cnt_reg - 12'h001;
      end
      if (wr_high && state_reg == DFP_HOLD) begin
        too_fast_reg <= 1'b1;
      end else if (state_reg == DFP_APPLY) begin
        too_fast_reg <= 1'b0;
      end
    end
  end

  // Late high writes during the hold window must not be lost.
  // The staged halves are kept, but the word is not replayed: firmware must
  // write the high half again once the window has passed.
  logic pending_reg;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pending_reg <= 1'b0;
    end else if (wr_high && state_reg != DFP_IDLE) begin
      pending_reg <= 1'b1;
    end else if (state_reg == DFP_IDLE) begin
      pending_reg <= 1'b0;
    end
  end

  // Range and resolution lookup; the two's complement word scales against
  // the half range, so it can never leave the selected range.
  dfp_range_rom u_range_rom (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .code_in(pull_range_reg),
    .half_range_out(half_range_out),
    .resolution_out(resolution_out)
  );

  // Outputs to the oscillator core.
  assign freq_offset_word_out = active_word_reg;
  assign pull_range_out = pull_range_reg;
  assign freq_update_out = freq_update_reg;
  assign update_too_fast_out = too_fast_reg | pending_reg;
  // Hardware mode follows the pin; software mode follows the stored bit.
  // The mode input is a strap level; changing it in operation switches the
  // enable source at once, with no filtering.
  assign out_enable_out = oe_sw_mode_in ? oe_sw_reg : oe_pin_in;

  // Read mux; unused bits and unmapped indices read as zero.
  // The read side has no wait state, so the slave may sample in any cycle.
  always_comb begin
    rd_data_out = 16'h0000;
    rd_valid_out = 1'b1;
    case (rd_addr_in)
      DFP_ADDR_OFFSET_LOW: rd_data_out = low_offset_half_reg;
      DFP_ADDR_OFFSET_HIGH: rd_data_out = {5'h00, oe_sw_reg, high_offset_half_reg};
      DFP_ADDR_PULL_RANGE: rd_data_out = {12'h000, pull_range_reg};
      default: rd_valid_out = 1'b0;
    endcase
  end
endmodule // dfp_regs

// ===== inc/dfp_pkg.sv
/*
 * Package for the digital frequency pull register bank: register indices,
 * field positions, reset values and the pull range resolution table.
 * Assumes a single 125 MHz clock domain and a register port that is
 * word addressed by register index.
 */
package dfp_pkg;
  // Register indices as seen on the register port.
  localparam logic [7:0] DFP_ADDR_OFFSET_LOW = 8'h00;
  localparam logic [7:0] DFP_ADDR_OFFSET_HIGH = 8'h01;
  localparam logic [7:0] DFP_ADDR_PULL_RANGE = 8'h02;
  localparam int DFP_NUM_REGS = 3;
  // Field layout.
  localparam int DFP_WORD_WIDTH = 26;
  localparam int DFP_HIGH_BITS = 10;
  localparam int DFP_OE_BIT = 10;
  localparam int DFP_RANGE_BITS = 4;
  // Reset values.
  localparam logic [15:0] DFP_OFFSET_LOW_RST = 16'h0000;
  localparam logic [9:0] DFP_OFFSET_HIGH_RST = 10'h000;
  localparam logic DFP_OE_RST = 1'b0;
  // Factory pull range code, arbitrary neutral default.
  localparam logic [3:0] DFP_RANGE_FACTORY = 4'h9;
  // Pull range codes: 0 = +-6.25 ppm ... 15 = +-3200 ppm.
  // Half range in hundredths of a ppm per code.
  localparam int DFP_RANGE_TABLE_DEPTH = 16;
  // Resolution per code in units of 1e-13 (5e-12 = 50).
  localparam logic [9:0] DFP_RES_UNIT_TABLE [16] = '{
    10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032, 10'h032,
    10'h032, 10'h032, 10'h064, 10'h08c, 10'h0d2, 10'h140, 10'h1d6, 10'h3ac};
  localparam logic [19:0] DFP_HALF_RANGE_CPPM [16] = '{
    20'h00271, 20'h003e8, 20'h004e2, 20'h009c4, 20'h01388, 20'h01f40,
    20'h02710, 20'h02ee0, 20'h03a98, 20'h04e20, 20'h09c40, 20'h0ea60,
    20'h13880, 20'h1d4c0, 20'h27100, 20'h4e200};
  // Update pacing: 38 kHz at 125 MHz, rounded up, gives 3290 cycles between commits.
  localparam int DFP_CLK_HZ = 125000000;
  localparam int DFP_MAX_UPDATE_HZ = 38000;
  localparam logic [11:0] DFP_UPDATE_CYCLES = 12'((DFP_CLK_HZ + DFP_MAX_UPDATE_HZ - 1)
    / DFP_MAX_UPDATE_HZ);
  // Commit state machine.
  typedef enum logic [1:0] {
    DFP_IDLE = 2'b00,
    DFP_APPLY = 2'b01,
    DFP_HOLD = 2'b10
  } dfp_state_type;
endpackage

// ===== verilog/dfp_range_rom.sv
/*
 * Small lookup memory that turns a pull range code into its half range and
 * frequency step resolution. Read data come out of a register, one cycle
 * after the code is presented. Assumes the dfp_pkg package is compiled first.
 */
`timescale 1ns/1ns
module dfp_range_rom (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Lookup.
  input wire logic [3:0] code_in,
  output logic [19:0] half_range_out,
  output logic [9:0] resolution_out
);
  import dfp_pkg::*;

  // Registered read; reset shows the factory range so consumers see a valid entry.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      half_range_out <= DFP_HALF_RANGE_CPPM[DFP_RANGE_FACTORY];
      resolution_out <= DFP_RES_UNIT_TABLE[DFP_RANGE_FACTORY];
    end else begin
      half_range_out <= DFP_HALF_RANGE_CPPM[code_in];
      resolution_out <= DFP_RES_UNIT_TABLE[code_in];
    end
  end
endmodule // dfp_range_rom

// ===== verif/dfp_regs_chk.sv
/* Port checker of the register bank.
   Assumes it is bound to dfp_regs and sees only its ports. */
`timescale 1ns/1ns
module dfp_regs_chk import dfp_pkg::*; (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register ports.
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_valid_out,
  // Output enable.
  input wire logic oe_sw_mode_in,
  input wire logic oe_pin_in,
  input wire logic out_enable_out,
  // Oscillator control.
  input wire logic [DFP_WORD_WIDTH-1:0] freq_offset_word_out,
  input wire logic [3:0] pull_range_out,
  input wire logic [19:0] half_range_out,
  input wire logic [9:0] resolution_out,
  input wire logic freq_update_out,
  input wire logic update_too_fast_out
);
  // One clock domain, so one default clock and disable.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_reset_state: assert property ($past(sys_rst_in) |-> freq_offset_word_out == 26'h0000000
    && pull_range_out == DFP_RANGE_FACTORY) else $error("Bad state after reset.");
  a_sw_oe_reset: assert property ($past(sys_rst_in) && oe_sw_mode_in |-> !out_enable_out)
    else $error("Enable set after reset.");
  a_hw_oe_pin: assert property (!oe_sw_mode_in |-> out_enable_out == oe_pin_in)
    else $error("Enable does not follow pin.");
  a_word_held: assert property (!freq_update_out && !$past(sys_rst_in)
    |-> $stable(freq_offset_word_out)) else $error("Word moved without update.");
  a_update_gap: assert property (freq_update_out |=> !freq_update_out [*8])
    else $error("Updates too close.");
  a_read_map: assert property (rd_valid_out == (rd_addr_in < 8'h03)
    && (rd_valid_out || rd_data_out == 16'h0000)) else $error("Bad unmapped read.");
  a_high_unused: assert property (rd_addr_in == DFP_ADDR_OFFSET_HIGH
    |-> rd_data_out[15:11] == 5'h00) else $error("Unused high bits set.");
  a_range_read: assert property (rd_addr_in == DFP_ADDR_PULL_RANGE
    |-> rd_data_out == {12'h000, pull_range_out}) else $error("Bad range read.");
  a_range_lookup: assert property (!$past(sys_rst_in) |-> half_range_out
    == DFP_HALF_RANGE_CPPM[$past(pull_range_out)] && resolution_out
    == DFP_RES_UNIT_TABLE[$past(pull_range_out)]) else $error("Bad range lookup.");
endmodule // dfp_regs_chk

// ===== verif/dfp_host_model.sv
/* Behavioural host driving the decoded write port of the bank.
   Assumes the bench clock and a bank that is out of reset. */
`timescale 1ns/1ns
module dfp_host_model import dfp_pkg::*; (
  // Clock.
  input wire logic clk_in,
  // Write port toward the bank.
  output logic wr_en_out = 1'b0,
  output logic [7:0] wr_addr_out = 8'h00,
  output logic [15:0] wr_data_out = 16'h0000
);
  // One strobe per write; the data bus shows no stale value afterwards.
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~d;
  endtask
  // Rounded scaled word, low half first, enable kept, then paced.
  task automatic set_ppm(input int cppm, input int half);
    longint n;
    logic [25:0] w;
    n = 64'sd33554431 * cppm;
    w = 26'((n + (n < 0 ? -half / 2 : half / 2)) / half);
    write(DFP_ADDR_OFFSET_LOW, w[15:0]);
    write(DFP_ADDR_OFFSET_HIGH, {5'h00, 1'b1, w[25:16]});
    repeat (DFP_UPDATE_CYCLES) @(posedge clk_in);
  endtask
endmodule // dfp_host_model

// ===== verif/dfp_regs_bench.sv
/* Self-checking bench of the bank with host model and register shadow.
   Assumes dfp_pkg, the design, the host model and the checker. */
`timescale 1ns/1ns
module dfp_regs_bench;
  import dfp_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] rd_addr_in = 8'h00;
  logic oe_sw_mode_in = 1'b0;
  logic oe_pin_in = 1'b0;
  logic wr_en_in;
  logic [7:0] wr_addr_in;
  logic [15:0] wr_data_in, rd_data_out;
  logic rd_valid_out, out_enable_out, freq_update_out, update_too_fast_out;
  logic [25:0] freq_offset_word_out;
  logic [3:0] pull_range_out;
  logic [19:0] half_range_out;
  logic [9:0] resolution_out;
  int miscompares = 0;
  int num_checks = 0;
  int updates = 0;
  int shadow [3] = '{0, 0, int'(DFP_RANGE_FACTORY)};
  always #4 clk_in = ~clk_in;
  dfp_host_model i_host (.clk_in(clk_in), .wr_en_out(wr_en_in), .wr_addr_out(wr_addr_in),
    .wr_data_out(wr_data_in));
  dfp_regs i_dut (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(wr_en_in),
    .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .oe_sw_mode_in(oe_sw_mode_in),
    .oe_pin_in(oe_pin_in),
    .out_enable_out(out_enable_out),
    .freq_offset_word_out(freq_offset_word_out),
    .pull_range_out(pull_range_out),
    .half_range_out(half_range_out),
    .resolution_out(resolution_out),
    .freq_update_out(freq_update_out),
    .update_too_fast_out(update_too_fast_out)
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    rd_addr_in <= a;
    @(negedge clk_in);
    chk("read", e, rd_data_out);
    chk("valid", a < 8'h03, rd_valid_out);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Shadow keeps what each write may change; bit 10 only in software mode.
  always @(posedge clk_in) begin
    if (wr_en_in === 1'b1 && wr_addr_in == 8'h00) shadow[0] = wr_data_in;
    if (wr_en_in === 1'b1 && wr_addr_in == 8'h02) shadow[2] = wr_data_in & 16'h000f;
    if (wr_en_in === 1'b1 && wr_addr_in == 8'h01) shadow[1] = (wr_data_in & 16'h03ff)
      | ((oe_sw_mode_in ? wr_data_in : shadow[1]) & 16'h0400);
  end
  // Every applied word must equal the staged halves.
  always @(negedge clk_in) begin
    if (freq_update_out === 1'b1) begin
      updates++;
      chk("word", {shadow[1][9:0], shadow[0][15:0]}, freq_offset_word_out);
    end
  end
  initial begin
    int i;
    int half;
    int ppm [3];
    i = $urandom(25455);
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    oe_sw_mode_in <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    rd(8'h02, {12'h000, DFP_RANGE_FACTORY});
    rd(8'h03, 16'h0000);
    chk("oe", 1'b0, out_enable_out);
    // Commit with unused bits set, then an early high write in pin mode, staged but not applied.
    i_host.write(8'h01, 16'hfc00);
    for (i = 0; i < 20 && freq_update_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 20) begin
      miscompares++;
      end_of_test();
    end
    chk("oe", 1'b1, out_enable_out);
    @(posedge clk_in);
    oe_sw_mode_in <= 1'b0;
    oe_pin_in <= 1'b0;
    i_host.write(8'h01, 16'h0155);
    repeat (4) @(negedge clk_in);
    chk("pin", 1'b0, out_enable_out);
    @(posedge clk_in);
    oe_pin_in <= 1'b1;
    @(negedge clk_in);
    chk("pin", 1'b1, out_enable_out);
    chk("too_fast", 1'b1, update_too_fast_out);
    rd(8'h01, 16'h0555);
    i_host.write(8'h00, 16'($urandom));
    repeat (DFP_UPDATE_CYCLES) @(negedge clk_in);
    chk("held", 26'h0000000, freq_offset_word_out);
    @(posedge clk_in);
    oe_sw_mode_in <= 1'b1;
    // Every range code, with random junk in the unused bits.
    for (i = 0; i < 16; i++) begin
      i_host.write(8'h02, {12'($urandom), 4'(i)});
      rd(8'h02, 16'(i));
      chk("range", i, pull_range_out);
      chk("half", DFP_HALF_RANGE_CPPM[i], half_range_out);
      chk("res", DFP_RES_UNIT_TABLE[i], resolution_out);
    end
    half = int'(DFP_HALF_RANGE_CPPM[15]);
    ppm = '{half, -half, int'($urandom_range(2 * half)) - half};
    foreach (ppm[k]) i_host.set_ppm(ppm[k], half);
    chk("updates", 32'd4, updates);
    chk("oe_kept", 1'b1, out_enable_out);
    chk("too_fast", 1'b0, update_too_fast_out);
    end_of_test();
  end
endmodule // dfp_regs_bench
bind dfp_regs dfp_regs_chk i_chk (.*);
